// ---- src/sdh_pkg.sv ----
// Purpose: shared constants for the sd host data-path control block
// Assumes: 32-bit register port, byte addresses as printed
// Notes:   status register offset is a local choice
package sdh_pkg;
    localparam logic [31:0] ADDR_BLEN = 32'h5A000028;
    localparam logic [31:0] ADDR_DCTL = 32'h5A00002C;
    localparam logic [31:0] ADDR_DCNT = 32'h5A000030;
    localparam logic [31:0] ADDR_STAT = 32'h5A000044;
    localparam logic [31:0] CTL_MASK  = 32'h003FFFFF;
    localparam logic [31:0] RST_WORD  = 32'h00000000;
    localparam int CTL_PRD   = 21;
    localparam int CTL_TX_AFTER_RESPONSE = 20;
    localparam int CTL_RX_AFTER_COMMAND = 19;
    localparam int CTL_BUSY_AFTER_COMMAND = 18;
    localparam int CTL_BLK   = 17;
    localparam int CTL_WIDE  = 16;
    localparam int CTL_DMA   = 15;
    localparam int CTL_STOP  = 14;
    localparam int DIR_MSB   = 13;
    localparam int DIR_LSB   = 12;
    localparam int CNT_MSB   = 11;
    localparam int RMN_BLK_LSB = 12;
    localparam int ST_RX = 0;
    localparam int ST_TX = 1;
    localparam int ST_BUSY = 2;
    localparam int ST_BUSY_FIN = 3;
    localparam int ST_DATA_FIN = 4;
    localparam int ST_POLL = 5;
    localparam logic [11:0] CNT_ONE  = 12'h001;
    localparam logic [11:0] CNT_ZERO = 12'h000;
    localparam logic [3:0]  BITS_NARROW = 4'h8;
    localparam logic [3:0]  BITS_WIDE   = 4'h2;
    localparam logic [3:0]  OE_NARROW   = 4'h1;
    localparam logic [3:0]  OE_WIDE     = 4'hF;
    localparam logic [7:0]  IRQ_SHORT_CYC = 8'h02;
    typedef enum logic [1:0] {
        DIR_IDLE = 2'h0,
        DIR_BUSY = 2'h1,
        DIR_RX   = 2'h2,
        DIR_TX   = 2'h3
    } sdh_dir_type;
    typedef enum logic [1:0] {
        S_IDLE = 2'h0,
        S_WAIT = 2'h1,
        S_RUN  = 2'h3,
        S_FIN  = 2'h2
    } sdh_state_type;
endpackage : sdh_pkg

// ---- src/sdh_link_if.sv ----
// Purpose: carries one byte operation between the control and link domains
// Assumes: toggle request/acknowledge, payload stable while a request is open
// Notes:   none
`timescale 1ns/1ps
interface sdh_link_if;
    logic       req_tgl;
    logic [1:0] op;
    logic       wide;
    logic [7:0] tx_byte;
    logic       ack_tgl;
    logic [7:0] rx_byte;
    modport ctl (output req_tgl, op, wide, tx_byte, input ack_tgl, rx_byte);
    modport lnk (input req_tgl, op, wide, tx_byte, output ack_tgl, rx_byte);
endinterface : sdh_link_if

// ---- src/sdh_link.sv ----
// Purpose: moves one byte or waits out busy on the card data lines
// Assumes: card_clk runs while an operation is open
// Notes:   start bits and crc live elsewhere
`timescale 1ns/1ps
module sdh_link
    import sdh_pkg::*;
(
    input  wire logic       card_clk,     // link clock
    input  wire logic       rst_n,        // reset, other domain
    sdh_link_if.lnk         lnk,          // control side
    input  wire logic [3:0] dat_in,       // card data lines in
    output logic      [3:0] dat_out,      // card data lines out
    output logic      [3:0] dat_oe        // high while driving
);
    logic       rst_s1, rst_s2;
    logic       req_s1, req_s2, seen_q;
    logic [3:0] dat_s1, dat_s2;
    logic       act_q, wide_q, ack_q;
    logic [1:0] op_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q, rxb_q;

    // reset and pins synchronised into this domain
    always_ff @(posedge card_clk) begin
        rst_s1 <= rst_n;
        rst_s2 <= rst_s1;
        req_s1 <= lnk.req_tgl;
        req_s2 <= req_s1;
        dat_s1 <= dat_in;
        dat_s2 <= dat_s1;
    end

    assign lnk.ack_tgl = ack_q;
    assign lnk.rx_byte = rxb_q;

    always_ff @(posedge card_clk) begin
        if (!rst_s2) begin
            seen_q <= 1'b0;
            act_q <= 1'b0;
            wide_q <= 1'b0;
            ack_q <= 1'b0;
            op_q <= DIR_IDLE;
            cnt_q <= '0;
            sh_q <= '0;
            rxb_q <= '0;
            dat_out <= '0;
            dat_oe <= '0;
        end else if (!act_q) begin
            dat_oe <= '0;
            if (req_s2 != seen_q) begin
                seen_q <= req_s2;
                act_q <= 1'b1;
                op_q <= lnk.op;
                wide_q <= lnk.wide;
                sh_q <= lnk.tx_byte;
                cnt_q <= lnk.wide ? BITS_WIDE : BITS_NARROW;
            end
        end else if (op_q == DIR_BUSY) begin
            // busy ends when line 0 is released high
            if (dat_s2[0]) begin
                act_q <= 1'b0;
                ack_q <= ~ack_q;
            end
        end else if (cnt_q == 4'h0) begin
            dat_oe <= '0;
            act_q <= 1'b0;
            ack_q <= ~ack_q;
            if (op_q == DIR_RX) rxb_q <= sh_q;
        end else begin
            cnt_q <= cnt_q - 4'h1;
            if (op_q == DIR_TX) begin
                // narrow mode drives line 0 only
                dat_out <= wide_q ? sh_q[7:4] : {3'h0, sh_q[7]};
                dat_oe <= wide_q ? OE_WIDE : OE_NARROW;
                sh_q <= wide_q ? {sh_q[3:0], 4'h0} : {sh_q[6:0], 1'b0};
            end else begin
                sh_q <= wide_q ? {sh_q[3:0], dat_s2} : {sh_q[6:0], dat_s2[0]};
            end
        end
    end
endmodule : sdh_link

// ---- src/sdh_dxfer.sv ----
// Purpose: data transfer control and remaining-count registers of an sd host
// Assumes: cmd_sent and rsp_received are one-cycle pulses on mclk
// Notes:   one byte in flight at a time; no fifo inside
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
// Contract
// - after the last block the sdio interrupt period lasts two cycles, or longer when selected.
// - with tx_after_response set, a transmit start waits for the response to be received.
// - with rx_after_command set, a receive start waits for the command to be sent.
// - with busy_after_command set, a busy check waits for the command to be sent.
// - block_transfer_select chooses stream transfer at 0 and block transfer at 1.
// - four_line_enable chooses line 0 alone or all four data lines.
// - dma_request_enable chooses polling at 0 and dma requests at 1.
// - writing the forced-stop bit as 1 halts the ongoing transfer.
// - transfer_direction selects idle, busy check, receive or transmit.
// - block_count gives 0 to 4095 blocks and is ignored in stream mode.
// - blocks_remaining and bytes_remaining are readable in bits 23:12 and 11:0.
// - transfer completion is flagged when the remaining counter reaches zero.
// - block_length gives 0 to 4095 bytes, word aligned for multi-block use.
module sdh_dxfer
    import sdh_pkg::*;
#(
    parameter logic [7:0] IRQ_EXT_CYC = 8'h08      // extended interrupt period
)(
    input  wire logic        mclk,                  // system clock
    input  wire logic        rst_n,                 // sync reset, low
    input  wire logic [31:0] reg_addr,              // register address
    input  wire logic [31:0] reg_wdata,             // write data
    input  wire logic        reg_wr,                // write strobe
    input  wire logic        reg_rd,                // read strobe
    output logic      [31:0] reg_rdata,             // read data, next cycle
    input  wire logic        cmd_sent,              // command sent pulse
    input  wire logic        rsp_received,          // response received pulse
    input  wire logic [7:0]  tx_byte,               // byte to transmit
    input  wire logic        tx_valid,              // tx byte offered
    output logic             tx_ready,              // tx byte taken
    output logic      [7:0]  rx_byte,               // received byte
    output logic             rx_valid,              // rx byte pulse
    output logic             dma_req,               // dma service request
    output logic             poll_req,              // polling service request
    output logic             sdio_int_period,       // sdio interrupt period
    input  wire logic        card_clk,              // link clock
    input  wire logic [3:0]  card_data_lines_in,    // data lines in
    output logic      [3:0]  card_data_lines_out,   // data lines out
    output logic      [3:0]  card_data_lines_oe     // data lines enable
);
    import sdh_pkg::*;

    sdh_link_if lnk ();
    sdh_state_type st_q;
    sdh_dir_type   dir;
    logic [31:0] ctl_q;
    logic [11:0] blen_q, blocks_q, bytes_q;
    logic        req_q, ack_s1, ack_s2, ack_s3, pend_q;
    logic [7:0]  hold_q;
    logic        busy_fin_q, data_fin_q, last_blk;
    logic [7:0]  irq_cnt_q;
    logic        ctl_wr, stat_wr, start_now, go_evt, ack_evt, issue;

    function automatic logic defer_of(input logic [31:0] w);
        unique case (sdh_dir_type'(w[DIR_MSB:DIR_LSB]))
            DIR_TX:   defer_of = w[CTL_TX_AFTER_RESPONSE];
            DIR_RX:   defer_of = w[CTL_RX_AFTER_COMMAND];
            DIR_BUSY: defer_of = w[CTL_BUSY_AFTER_COMMAND];
            DIR_IDLE: defer_of = 1'b0;
        endcase
    endfunction : defer_of

    // run state in one direction, as the status view shows it
    function automatic logic run_in(input sdh_state_type s, input sdh_dir_type d, input sdh_dir_type want);
        run_in = (s == S_RUN) && (d == want);
    endfunction : run_in

    assign dir     = sdh_dir_type'(ctl_q[DIR_MSB:DIR_LSB]);
    assign ctl_wr  = reg_wr && (reg_addr == ADDR_DCTL);
    assign stat_wr = reg_wr && (reg_addr == ADDR_STAT);
    // a write with a direction and no stop starts a run
    assign start_now = ctl_wr && !reg_wdata[CTL_STOP] && (reg_wdata[DIR_MSB:DIR_LSB] != DIR_IDLE);
    assign go_evt  = (dir == DIR_TX) ? rsp_received : cmd_sent;
    assign ack_evt = ack_s2 ^ ack_s3;
    assign last_blk = (bytes_q == CNT_ONE) && (blocks_q == CNT_ONE);
    assign tx_ready = (st_q == S_RUN) && (dir == DIR_TX) && !pend_q && !ctl_wr;
    // no byte leaves beside a control write, so op and wide hold for the link
    assign issue = (st_q == S_RUN) && !pend_q && !ctl_wr && (dir != DIR_TX || tx_valid);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctl_q <= RST_WORD;
            blen_q <= CNT_ZERO;
        end else begin
            if (ctl_wr) ctl_q <= reg_wdata & CTL_MASK;
            if (reg_wr && reg_addr == ADDR_BLEN) blen_q <= reg_wdata[CNT_MSB:0];
        end
    end

    // ack crosses from the link domain as a toggle
    // the first stage feeds only the second; the third only finds the edge
    always_ff @(posedge mclk) begin
        ack_s1 <= lnk.ack_tgl;
        ack_s2 <= ack_s1;
        ack_s3 <= ack_s2;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_q <= S_IDLE;
        end else if (ctl_wr) begin
            // a control write outranks the events of the same cycle
            if (!start_now) st_q <= S_IDLE;
            else if (defer_of(reg_wdata)) st_q <= S_WAIT;
            else st_q <= S_RUN;
        end else begin
            unique case (st_q)
                S_IDLE: st_q <= S_IDLE;
                S_WAIT: if (go_evt) st_q <= S_RUN;
                S_RUN: begin
                    // block mode with nothing to move finishes at once
                    if (dir != DIR_BUSY && ctl_q[CTL_BLK] &&
                        (blocks_q == CNT_ZERO || bytes_q == CNT_ZERO)) st_q <= S_FIN;
                    else if (ack_evt && pend_q && dir == DIR_BUSY) st_q <= S_FIN;
                    else if (ack_evt && pend_q && ctl_q[CTL_BLK] && last_blk) st_q <= S_FIN;
                end
                S_FIN: st_q <= S_IDLE;
            endcase
        end
    end

    // counters load on entry to run; stream mode leaves them alone
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            blocks_q <= CNT_ZERO;
            bytes_q <= CNT_ZERO;
        end else if (st_q != S_RUN && !ctl_wr && (st_q == S_WAIT ? go_evt : 1'b0) && ctl_q[CTL_BLK]) begin
            blocks_q <= ctl_q[CNT_MSB:0];
            bytes_q <= blen_q;
        end else if (start_now && !defer_of(reg_wdata) && reg_wdata[CTL_BLK]) begin
            blocks_q <= reg_wdata[CNT_MSB:0];
            bytes_q <= blen_q;
        end else if (st_q == S_RUN && ack_evt && pend_q && ctl_q[CTL_BLK] && dir != DIR_BUSY) begin
            if (bytes_q != CNT_ONE) begin
                bytes_q <= bytes_q - CNT_ONE;
            end else begin
                blocks_q <= blocks_q - CNT_ONE;
                bytes_q <= (blocks_q == CNT_ONE) ? CNT_ZERO : blen_q;
            end
        end
    end

    // one byte in flight; a stop lets it drain before the next start
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            req_q <= 1'b0;
            pend_q <= 1'b0;
            hold_q <= '0;
            rx_byte <= '0;
            rx_valid <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            if (issue) begin
                req_q <= ~req_q;
                pend_q <= 1'b1;
                if (dir == DIR_TX) hold_q <= tx_byte;
            end else if (ack_evt) begin
                pend_q <= 1'b0;
                if (st_q == S_RUN && dir == DIR_RX) begin
                    rx_byte <= lnk.rx_byte;
                    rx_valid <= 1'b1;
                end
            end
        end
    end

    assign lnk.req_tgl = req_q;
    assign lnk.op      = dir;
    assign lnk.wide    = ctl_q[CTL_WIDE];
    assign lnk.tx_byte = hold_q;

    // service requests go to dma or to polling
    assign dma_req  = ctl_q[CTL_DMA] && (tx_ready || rx_valid);
    assign poll_req = !ctl_q[CTL_DMA] && (tx_ready || rx_valid);

    // done flags: hardware set wins over software clear
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            busy_fin_q <= 1'b0;
            data_fin_q <= 1'b0;
        end else begin
            if (st_q == S_FIN && dir == DIR_BUSY) busy_fin_q <= 1'b1;
            else if (stat_wr && reg_wdata[ST_BUSY_FIN]) busy_fin_q <= 1'b0;
            if (st_q == S_FIN && dir != DIR_BUSY) data_fin_q <= 1'b1;
            else if (stat_wr && reg_wdata[ST_DATA_FIN]) data_fin_q <= 1'b0;
        end
    end

    // interrupt period after the last block
    always_ff @(posedge mclk) begin
        if (!rst_n) irq_cnt_q <= '0;
        else if (st_q == S_FIN && dir != DIR_BUSY && ctl_q[CTL_BLK])
            irq_cnt_q <= ctl_q[CTL_PRD] ? IRQ_EXT_CYC : IRQ_SHORT_CYC;
        else if (irq_cnt_q != 8'h00) irq_cnt_q <= irq_cnt_q - 8'h01;
    end
    assign sdio_int_period = (irq_cnt_q != 8'h00);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reg_rdata <= RST_WORD;
        end else if (reg_rd) begin
            // data stand one cycle only and read as zero otherwise
            unique case (reg_addr)
                ADDR_DCTL: reg_rdata <= ctl_q;
                ADDR_BLEN: reg_rdata <= {20'h00000, blen_q};
                // remaining counts
                ADDR_DCNT: reg_rdata <= {8'h00, blocks_q, bytes_q};
                ADDR_STAT: reg_rdata <= {26'h0000000, poll_req, data_fin_q, busy_fin_q,
                                         run_in(st_q, dir, DIR_BUSY),
                                         run_in(st_q, dir, DIR_TX),
                                         run_in(st_q, dir, DIR_RX)};
                default:   reg_rdata <= RST_WORD;
            endcase
        end else begin
            reg_rdata <= RST_WORD;
        end
    end

    sdh_link u_link (
        .card_clk (card_clk),
        .rst_n    (rst_n),
        .lnk      (lnk.lnk),
        .dat_in   (card_data_lines_in),
        .dat_out  (card_data_lines_out),
        .dat_oe   (card_data_lines_oe)
    );

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_irq_start;
        st_q == S_FIN && dir != DIR_BUSY && ctl_q[CTL_BLK];
    endsequence
    sequence s_idle_wait;
        st_q == S_WAIT && !ctl_wr;
    endsequence
    // a byte of a block run acknowledged by the link
    sequence s_byte_step;
        st_q == S_RUN && ack_evt && pend_q && ctl_q[CTL_BLK] && dir != DIR_BUSY && !ctl_wr;
    endsequence

    // deferral checks skip cycles that carry a control write
    AST_IRQ_SHORT: assert property (s_irq_start ##0 !ctl_q[CTL_PRD] |=>
        sdio_int_period [*2] ##1 !sdio_int_period) else $error("short period not two cycles");

    AST_IRQ_LONG: assert property (s_irq_start ##0 ctl_q[CTL_PRD] |=>
        sdio_int_period && irq_cnt_q == IRQ_EXT_CYC) else $error("long period not loaded");

    AST_TX_DEFER: assert property (s_idle_wait ##0 dir == DIR_TX && !rsp_received
        |=> st_q == S_WAIT) else $error("transmit started before response");

    AST_RX_DEFER: assert property (s_idle_wait ##0 dir == DIR_RX && !cmd_sent
        |=> st_q == S_WAIT) else $error("receive started before command sent");

    AST_BUSY_DEFER: assert property (s_idle_wait ##0 dir == DIR_BUSY && cmd_sent
        |=> st_q == S_RUN) else $error("busy check not started on command sent");

    AST_IMMEDIATE: assert property (start_now && !reg_wdata[CTL_TX_AFTER_RESPONSE]
        && !reg_wdata[CTL_RX_AFTER_COMMAND] && !reg_wdata[CTL_BUSY_AFTER_COMMAND]
        |=> st_q == S_RUN) else $error("start not immediate");

    AST_DIR_IDLE: assert property (ctl_wr && reg_wdata[DIR_MSB:DIR_LSB] == DIR_IDLE
        |=> st_q == S_IDLE) else $error("ready mode did not idle");

    AST_STOP: assert property (ctl_wr && reg_wdata[CTL_STOP]
        |=> st_q == S_IDLE ##1 (st_q != S_RUN || $past(ctl_wr)))
        else $error("forced stop ignored");

    AST_DMA: assert property (dma_req |-> ctl_q[CTL_DMA] && !poll_req)
        else $error("dma request while disabled");

    AST_FINISH: assert property (st_q == S_RUN && ack_evt && pend_q && ctl_q[CTL_BLK]
        && dir != DIR_BUSY && last_blk && !ctl_wr |=> st_q == S_FIN ##1 data_fin_q && blocks_q == CNT_ZERO)
        else $error("finish not flagged at zero");

    AST_LOAD: assert property (start_now && !defer_of(reg_wdata) && reg_wdata[CTL_BLK]
        |=> blocks_q == $past(reg_wdata[CNT_MSB:0]) && bytes_q == blen_q) else $error("counters not loaded");

    AST_STREAM_HOLD: assert property (st_q == S_RUN && !ctl_q[CTL_BLK] && !ctl_wr
        |=> $stable(blocks_q) && $stable(bytes_q)) else $error("stream run moved counters");

    AST_BYTE_STEP: assert property (s_byte_step ##0 bytes_q > CNT_ONE
        |=> bytes_q == $past(bytes_q) - CNT_ONE && $stable(blocks_q))
        else $error("byte count did not step");

    AST_DEFER_LOAD: assert property (st_q == S_WAIT && go_evt && !ctl_wr && ctl_q[CTL_BLK]
        |=> st_q == S_RUN && blocks_q == $past(ctl_q[CNT_MSB:0]) && bytes_q == $past(blen_q))
        else $error("deferred start did not load counters");

    AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == RST_WORD)
        else $error("read data outside its cycle");

    AST_CNT_VIEW: assert property (reg_rd && reg_addr == ADDR_DCNT
        |=> reg_rdata == {8'h00, $past(blocks_q), $past(bytes_q)})
        else $error("remaining counts misread");
endmodule : sdh_dxfer

// ---- bench/sdh_card_model.sv ----
// Purpose: card side of the data lines: resolves the wires, captures host bytes
// Assumes: released lines are pulled up; busy shows as line 0 held low
// Notes:   capture is sampled on the falling link edge, away from host updates
`timescale 1ns/1ps
module sdh_card_model
    import sdh_pkg::*;
(
    input  wire logic       card_clk,   // link clock
    input  wire logic       clr,        // clear capture
    input  wire logic       busy_hold,  // card busy
    input  wire logic [3:0] host_out,   // host drive
    input  wire logic [3:0] host_oe,    // host enable
    output logic      [3:0] lines,      // resolved lines
    output logic      [7:0] cap_byte,   // captured byte
    output logic      [7:0] cap_beats   // driven beats
);
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            // pull-ups win wherever nobody drives, except line 0 while the card is busy
            lines[i] = host_oe[i] ? host_out[i] : !(i == 0 && busy_hold);
        end
    end
    always @(negedge card_clk) begin
        if (clr) begin
            cap_byte  <= 8'h00;
            cap_beats <= 8'h00;
        end else if (host_oe == OE_WIDE) begin
            cap_byte  <= {cap_byte[3:0], host_out};
            cap_beats <= cap_beats + 8'h01;
        end else if (host_oe[0]) begin
            cap_byte  <= {cap_byte[6:0], host_out[0]};
            cap_beats <= cap_beats + 8'h01;
        end
    end
endmodule : sdh_card_model

// ---- bench/sdh_dxfer_tb.sv ----
// Purpose: register-level tests of the data transfer control block
// Assumes: one byte in flight; polling or dma chosen per test
// Notes:   extended interrupt period shortened to keep runs brief
`timescale 1ns/1ps
module sdh_dxfer_tb;
    import sdh_pkg::*;
    localparam logic [7:0] EXT = 8'h05;
    logic        mclk = 0, card_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
    logic        cmd_sent = 0, rsp_received = 0, tx_valid = 0, busy_hold = 0, clr = 1;
    logic [31:0] reg_addr = 0, reg_wdata = 0, reg_rdata, d;
    logic [7:0]  tx_byte = 0, rx_byte, rx_last, cap_byte, cap_beats;
    logic        tx_ready, rx_valid, dma_req, poll_req, sdio_int_period;
    logic [3:0]  lines, l_out, l_oe;
    int          n_fail = 0, n_checks = 0, rx_cnt = 0, irq_cyc = 0;

    sdh_dxfer #(.IRQ_EXT_CYC(EXT)) u_sdh_dxfer (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cmd_sent(cmd_sent), .rsp_received(rsp_received), .tx_byte(tx_byte), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rx_byte(rx_byte), .rx_valid(rx_valid), .dma_req(dma_req),
        .poll_req(poll_req), .sdio_int_period(sdio_int_period), .card_clk(card_clk),
        .card_data_lines_in(lines), .card_data_lines_out(l_out), .card_data_lines_oe(l_oe));
    sdh_card_model u_sdh_card_model (.card_clk(card_clk), .clr(clr), .busy_hold(busy_hold),
        .host_out(l_out), .host_oe(l_oe), .lines(lines), .cap_byte(cap_byte), .cap_beats(cap_beats));

    always #4 mclk = ~mclk;
    initial begin
        #1.3;
        forever #3 card_clk = ~card_clk;
    end
    always @(posedge mclk) begin
        if (rx_valid === 1'b1) begin
            rx_cnt  <= rx_cnt + 1;
            rx_last <= rx_byte;
        end
        if (sdio_int_period === 1'b1) begin
            irq_cyc <= irq_cyc + 1;
        end
    end

    task automatic finish_test;
        $display("checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [31:0] a, output logic [31:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        @(negedge mclk);
        v = reg_rdata;
    endtask : rd
    task automatic pulse(input logic rsp);
        @(posedge mclk);
        if (rsp) rsp_received <= 1'b1;
        else cmd_sent <= 1'b1;
        @(posedge mclk);
        rsp_received <= 1'b0;
        cmd_sent     <= 1'b0;
    endtask : pulse
    // bounded wait: 0 tx_ready, 1 card beats reach n, 2 rx bytes reach n
    task automatic wait_for(input int sel, input int n);
        for (int i = 0; i < 2000; i++) begin
            @(negedge mclk);
            if ((sel == 0 && tx_ready === 1'b1) || (sel == 1 && cap_beats === n[7:0]) ||
                (sel == 2 && rx_cnt == n)) return;
        end
        n_fail++;
        $display("CHECK FAILED wait %0d expected done seen timeout", sel);
        finish_test;
    endtask : wait_for
    task automatic send(input logic [7:0] b, input logic dma, input int beats);
        clr <= 1'b1;
        tick(2);
        clr      <= 1'b0;
        tx_byte  <= b;
        tx_valid <= 1'b1;
        wait_for(0, 0);
        chk("dma_req", dma_req, dma);
        chk("poll_req", poll_req, !dma);
        @(posedge mclk);
        tx_valid <= 1'b0;
        wait_for(1, beats);
        chk("card byte", cap_byte, b);
        // let the acknowledge cross before counters are read
        tick(4);
    endtask : send

    initial begin
        tick(10);
        rst_n <= 1'b1;
        // reset values, unmapped and read-only places
        rd(ADDR_DCTL, d);
        chk("ctl reset", d, RST_WORD);
        rd(ADDR_DCNT, d);
        chk("cnt reset", d, RST_WORD);
        rd(32'h5A000040, d);
        chk("unmapped", d, 32'h00000000);
        wr(ADDR_DCNT, 32'hFFFFFFFF);
        rd(ADDR_DCNT, d);
        chk("cnt read-only", d, 32'h00000000);
        wr(ADDR_DCTL, 32'hFFFFFFFF);
        rd(ADDR_DCTL, d);
        chk("ctl mask", d, CTL_MASK);
        rd(ADDR_STAT, d);
        chk("stopped idle", d & 32'h7, 32'h0);
        $display("test registers done");
        // narrow block transmit, two blocks of four, polling
        irq_cyc = 0;
        wr(ADDR_BLEN, 32'h00000004);
        wr(ADDR_DCTL, 32'h00023002);
        send(8'hA5, 1'b0, 8);
        rd(ADDR_DCNT, d);
        chk("counters", d, 32'h00002003);
        for (int k = 1; k < 8; k++) send(8'h10 + k[7:0], 1'b0, 8);
        tick(30);
        chk("irq short", irq_cyc, 2);
        rd(ADDR_DCNT, d);
        chk("counters done", d, 32'h0);
        rd(ADDR_STAT, d);
        chk("data finish", d[ST_DATA_FIN], 1'b1);
        wr(ADDR_STAT, 32'h00000018);
        rd(ADDR_STAT, d);
        chk("finish cleared", d[ST_DATA_FIN], 1'b0);
        $display("test narrow tx done");
        // wide dma transmit held back until the response arrives
        irq_cyc = 0;
        wr(ADDR_DCTL, 32'h0033B001);
        tick(20);
        @(negedge mclk);
        chk("tx deferred", tx_ready, 1'b0);
        pulse(1'b1);
        for (int k = 0; k < 4; k++) send(8'h3C + k[7:0], 1'b1, 2);
        tick(30);
        chk("irq long", irq_cyc, EXT);
        wr(ADDR_DCTL, 32'h00000000);
        wr(ADDR_STAT, 32'h00000018);
        $display("test wide tx done");
        // narrow receive held back until the command is sent
        rx_cnt = 0;
        wr(ADDR_BLEN, 32'h00000002);
        wr(ADDR_DCTL, 32'h000A2001);
        tick(20);
        chk("rx deferred", rx_cnt, 0);
        pulse(1'b0);
        wait_for(2, 2);
        tick(40);
        chk("rx count", rx_cnt, 2);
        chk("rx byte", rx_last, 8'hFF);
        rd(ADDR_STAT, d);
        chk("rx finish", d[ST_DATA_FIN], 1'b1);
        wr(ADDR_STAT, 32'h00000018);
        $display("test rx done");
        // busy check waits for the command before looking at line 0
        wr(ADDR_DCTL, 32'h00041000);
        tick(20);
        rd(ADDR_STAT, d);
        chk("busy deferred", d[ST_BUSY_FIN], 1'b0);
        busy_hold <= 1'b1;
        pulse(1'b0);
        tick(40);
        rd(ADDR_STAT, d);
        chk("busy held", d[ST_BUSY_FIN:ST_BUSY], 2'b01);
        busy_hold <= 1'b0;
        tick(40);
        rd(ADDR_STAT, d);
        chk("busy finish", d[ST_BUSY_FIN], 1'b1);
        wr(ADDR_STAT, 32'h00000018);
        $display("test busy done");
        // stream transmit ignores the count, then a forced stop
        wr(ADDR_DCTL, 32'h00003005);
        send(8'h5A, 1'b0, 8);
        send(8'hC3, 1'b0, 8);
        rd(ADDR_DCNT, d);
        chk("stream counters", d, 32'h0);
        wr(ADDR_DCTL, 32'h00007000);
        tick(3);
        @(negedge mclk);
        chk("stop ready", tx_ready, 1'b0);
        rd(ADDR_STAT, d);
        chk("stop tx off", d[ST_TX], 1'b0);
        $display("test stream stop done");
        finish_test;
    end
endmodule : sdh_dxfer_tb
